/* cwd_config_word_one_decode.sv */
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module cwd_config_word_one_decode
  import cwd_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  input  wire logic [13:0] i_nv_word,
  input  wire logic        i_low_voltage_prog_en,
  input  wire logic        i_sleep_active,
  input  wire logic        i_startup_timer_done,
  input  wire logic        i_ext_clk_failed,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic             o_fail_safe_monitor_en,
  output logic             o_two_speed_switchover_en,
  output logic             o_clock_out_drive,
  output logic             o_brownout_active,
  output logic             o_program_protect,
  output logic             o_reset_pin_is_master_reset,
  output logic             o_reset_pin_pullup_en,
  output logic             o_powerup_timer_en,
  output logic             o_watchdog_active,
  output logic             o_use_internal_clk,
  output logic             o_osc_fail_flag,
  output logic             o_config_loaded
);

  cwd_load_state_t load_state;
  cwd_load_state_t next_load_state;
  cwd_cfg_t        cfg;
  cwd_cfg_t        next_cfg;

  logic [2:0]  ctrl;
  logic [2:0]  next_ctrl;
  logic        wr_pending;
  logic        next_wr_pending;
  logic [31:0] wr_addr;
  logic [31:0] next_wr_addr;
  logic [31:0] next_hrdata;

  logic        fail_flag;
  logic        next_fail_flag;
  logic        internal_clk;
  logic        next_internal_clk;

  logic        next_monitor_en;
  logic        next_switch_en;
  logic        next_clock_out;
  logic        next_bor_active;
  logic        next_protect;
  logic        next_mclr;
  logic        next_pullup;
  logic        next_pwrt_en;
  logic        next_wdt_active;

  logic [13:0] word_view;
  logic        addr_phase;
  logic        restart_req;
  logic        fail_clear;
  logic        fail_set;
  logic        crystal_mode;

  // The word is captured once, on the first edge after reset release.
  always_comb begin
    next_load_state = load_state;
    next_cfg        = cfg;
    unique case (load_state)
      CWD_CAPTURE: begin
        next_cfg.fail_safe_monitor_en    = i_nv_word[CWD_BIT_MONITOR];
        next_cfg.two_speed_switchover_en = i_nv_word[CWD_BIT_SWITCH];
        next_cfg.clock_out_pin_en_n      = i_nv_word[CWD_BIT_CLKOUT_N];
        next_cfg.brownout_policy_sel     = i_nv_word[CWD_BIT_BOR_HI:CWD_BIT_BOR_LO];
        next_cfg.program_protect_n       = i_nv_word[CWD_BIT_PROTECT_N];
        next_cfg.reset_pin_func_sel      = i_nv_word[CWD_BIT_RESET_PIN];
        next_cfg.powerup_timer_en_n      = i_nv_word[CWD_BIT_PWRT_N];
        next_cfg.watchdog_policy_sel     = i_nv_word[CWD_BIT_WDT_HI:CWD_BIT_WDT_LO];
        next_cfg.oscillator_source_sel   = i_nv_word[CWD_BIT_OSC_HI:CWD_BIT_OSC_LO];
        next_load_state                  = CWD_HOLD; // (R12)
      end
      CWD_HOLD: begin
        next_load_state = CWD_HOLD; // (R12)
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      load_state <= CWD_CAPTURE;
      cfg        <= CWD_CFG_ERASED; // (R1)
    end else begin
      load_state <= next_load_state;
      cfg        <= next_cfg;
    end
  end

  always_comb begin
    word_view = {cfg.fail_safe_monitor_en, cfg.two_speed_switchover_en,
                 cfg.clock_out_pin_en_n, cfg.brownout_policy_sel, 1'b1,
                 cfg.program_protect_n, cfg.reset_pin_func_sel,
                 cfg.powerup_timer_en_n, cfg.watchdog_policy_sel,
                 cfg.oscillator_source_sel}; // (R10)
  end

  // Zero-wait slave: read data is registered at the address phase edge.
  always_comb begin
    addr_phase      = i_hsel && i_htrans[1] && i_hready;
    next_wr_pending = addr_phase && i_hwrite;
    next_wr_addr    = addr_phase ? i_haddr : wr_addr;
    next_hrdata     = 32'h0000_0000;
    next_ctrl       = ctrl;
    restart_req     = 1'b0;
    if (wr_pending && wr_addr == CWD_ADDR_CTRL) begin
      next_ctrl   = i_hwdata[CWD_CTRL_WPU:CWD_CTRL_SW_BOR];
      restart_req = i_hwdata[CWD_CTRL_RESTART];
    end
    if (addr_phase && !i_hwrite) begin
      unique case (i_haddr)
        CWD_ADDR_WORD: begin
          next_hrdata = {18'h0_0000, word_view};
        end
        CWD_ADDR_CTRL: begin
          next_hrdata = {29'h0000_0000, next_ctrl};
        end
        CWD_ADDR_STATUS: begin
          next_hrdata = {29'h0000_0000, load_state == CWD_HOLD, internal_clk, fail_flag};
        end
        default: begin
          next_hrdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_pending  <= 1'b0;
      wr_addr     <= 32'h0000_0000;
      ctrl        <= CWD_CTRL_RESET;
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      wr_pending  <= next_wr_pending;
      wr_addr     <= next_wr_addr;
      ctrl        <= next_ctrl;
      o_hrdata    <= next_hrdata;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end

  // A new failure in the same cycle as a clear keeps the flag set.
  always_comb begin
    fail_set   = cfg.fail_safe_monitor_en && i_startup_timer_done && i_ext_clk_failed; // (R11)
    fail_clear = wr_pending && wr_addr == CWD_ADDR_STATUS && i_hwdata[CWD_STAT_FAIL];
    next_fail_flag    = fail_set || (fail_flag && !fail_clear); // (R11)
    next_internal_clk = internal_clk;
    if (fail_set) begin
      next_internal_clk = 1'b1; // (R11)
    end else if (restart_req || i_sleep_active) begin
      next_internal_clk = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fail_flag    <= 1'b0;
      internal_clk <= 1'b0;
    end else begin
      fail_flag    <= next_fail_flag;
      internal_clk <= next_internal_clk;
    end
  end

  always_comb begin
    crystal_mode = cfg.oscillator_source_sel == CWD_OSC_LP ||
                   cfg.oscillator_source_sel == CWD_OSC_XT ||
                   cfg.oscillator_source_sel == CWD_OSC_HS;
    next_monitor_en = cfg.fail_safe_monitor_en; // (R2)
    next_switch_en  = cfg.two_speed_switchover_en || cfg.fail_safe_monitor_en; // (R2) (R3)
    next_clock_out  = !crystal_mode && !cfg.clock_out_pin_en_n; // (R4)
    next_protect    = !cfg.program_protect_n; // (R6)
    next_mclr       = i_low_voltage_prog_en || cfg.reset_pin_func_sel; // (R7)
    next_pullup     = next_mclr ? 1'b1 : ctrl[CWD_CTRL_WPU]; // (R7)
    next_pwrt_en    = !cfg.powerup_timer_en_n; // (R8)
    unique case (cfg.brownout_policy_sel)
      CWD_POL_ALWAYS: next_bor_active = 1'b1; // (R5)
      CWD_POL_AWAKE:  next_bor_active = !i_sleep_active; // (R5)
      CWD_POL_SOFT:   next_bor_active = ctrl[CWD_CTRL_SW_BOR]; // (R5)
      CWD_POL_OFF:    next_bor_active = 1'b0; // (R5)
    endcase
    unique case (cfg.watchdog_policy_sel)
      CWD_POL_ALWAYS: next_wdt_active = 1'b1; // (R9)
      CWD_POL_AWAKE:  next_wdt_active = !i_sleep_active; // (R9)
      CWD_POL_SOFT:   next_wdt_active = ctrl[CWD_CTRL_SW_WDT]; // (R9)
      CWD_POL_OFF:    next_wdt_active = 1'b0; // (R9)
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_fail_safe_monitor_en      <= 1'b1;
      o_two_speed_switchover_en   <= 1'b1;
      o_clock_out_drive           <= 1'b0;
      o_brownout_active           <= 1'b1;
      o_program_protect           <= 1'b0;
      o_reset_pin_is_master_reset <= 1'b1;
      o_reset_pin_pullup_en       <= 1'b1;
      o_powerup_timer_en          <= 1'b0;
      o_watchdog_active           <= 1'b1;
      o_use_internal_clk          <= 1'b0;
      o_osc_fail_flag             <= 1'b0;
      o_config_loaded             <= 1'b0;
    end else begin
      o_fail_safe_monitor_en      <= next_monitor_en;
      o_two_speed_switchover_en   <= next_switch_en;
      o_clock_out_drive           <= next_clock_out;
      o_brownout_active           <= next_bor_active;
      o_program_protect           <= next_protect;
      o_reset_pin_is_master_reset <= next_mclr;
      o_reset_pin_pullup_en       <= next_pullup;
      o_powerup_timer_en          <= next_pwrt_en;
      o_watchdog_active           <= next_wdt_active;
      o_use_internal_clk          <= next_internal_clk;
      o_osc_fail_flag             <= next_fail_flag;
      o_config_loaded             <= load_state == CWD_HOLD;
    end
  end

endmodule

/* cwd_config_word_one_decode_bench.sv */
`timescale 1ns/10ps
module cwd_config_word_one_decode_bench;
  import cwd_pkg::*;
  logic        i_core_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic [13:0] i_nv_word = CWD_WORD_ERASED;
  logic        i_low_voltage_prog_en = 1'b0;
  logic        i_sleep_active = 1'b0;
  logic        i_startup_timer_done = 1'b0;
  logic        i_ext_clk_failed = 1'b0;
  logic        i_hsel = 1'b0;
  logic        i_hwrite = 1'b0;
  logic [1:0]  i_htrans = 2'h0;
  logic [2:0]  i_hsize = 3'h2;
  logic [31:0] i_haddr = 32'h0;
  logic [31:0] i_hwdata = 32'h0;
  wire logic   i_hready;
  logic [31:0] o_hrdata;
  logic [31:0] rd;
  logic        o_hreadyout, o_hresp, o_fail_safe_monitor_en, o_two_speed_switchover_en;
  logic        o_clock_out_drive, o_brownout_active, o_program_protect, o_powerup_timer_en;
  logic        o_reset_pin_is_master_reset, o_reset_pin_pullup_en, o_watchdog_active;
  logic        o_use_internal_clk, o_osc_fail_flag, o_config_loaded;
  int          err_count = 0;
  int          n_compared = 0;
  assign i_hready = o_hreadyout;
  cwd_config_word_one_decode cwd_config_word_one_decode_inst (.*);
  initial begin
    forever #50 i_core_clk = ~i_core_clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= a;
    i_hwrite <= wr;
    do @(posedge i_core_clk); while (i_hready !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_core_clk); while (i_hready !== 1'b1);
    rd = o_hrdata;
  endtask
  task automatic boot(input logic [13:0] w, input int n);
    i_nv_word <= w;
    i_arst_n <= 1'b0;
    repeat (n) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_core_clk);
  endtask
  // Reads the word back and compares the decoded outputs as one vector.
  task automatic look(input logic [31:0] ew, input logic [8:0] eo);
    bus(1'b0, CWD_ADDR_WORD, 32'h0);
    cmp(rd, ew);
    @(negedge i_core_clk);
    cmp({23'h0, o_fail_safe_monitor_en, o_two_speed_switchover_en, o_clock_out_drive,
         o_brownout_active, o_program_protect, o_reset_pin_is_master_reset,
         o_reset_pin_pullup_en, o_powerup_timer_en, o_watchdog_active}, {23'h0, eo});
    cmp({29'h0, o_config_loaded, o_hreadyout, o_hresp}, 32'h6);
    // Returns on a rising edge so that following stimulus is applied there.
    @(posedge i_core_clk);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    err_count++;
    complete_run();
  end
  initial begin
    boot(CWD_WORD_ERASED, 20);
    look(32'h3fff, 9'h1ad);
    $display("erased word done");
    boot(14'h0000, 2);
    look(32'h0100, 9'h012);
    $display("cleared word done");
    boot(14'h14d7, 2);
    look(32'h15d7, 9'h0ef);
    i_sleep_active <= 1'b1;
    look(32'h15d7, 9'h0ce);
    i_sleep_active <= 1'b0;
    $display("sleep policy done");
    boot(14'h2a29, 2);
    look(32'h2b29, 9'h190);
    bus(1'b1, CWD_ADDR_CTRL, 32'h5);
    bus(1'b0, CWD_ADDR_CTRL, 32'h0);
    cmp(rd, 32'h5);
    look(32'h2b29, 9'h1b4);
    i_low_voltage_prog_en <= 1'b1;
    i_nv_word <= 14'h0000;
    bus(1'b1, CWD_ADDR_WORD, 32'h0);
    look(32'h2b29, 9'h1bc);
    $display("software policy done");
    @(posedge i_core_clk);
    i_startup_timer_done <= 1'b1;
    i_ext_clk_failed <= 1'b1;
    @(posedge i_core_clk);
    i_ext_clk_failed <= 1'b0;
    @(negedge i_core_clk);
    cmp({30'h0, o_osc_fail_flag, o_use_internal_clk}, 32'h3);
    bus(1'b0, CWD_ADDR_STATUS, 32'h0);
    cmp(rd, 32'h7);
    bus(1'b1, CWD_ADDR_STATUS, 32'h1);
    bus(1'b1, CWD_ADDR_CTRL, 32'hd);
    bus(1'b0, CWD_ADDR_STATUS, 32'h0);
    cmp(rd, 32'h4);
    bus(1'b0, 32'h10, 32'h0);
    cmp(rd, 32'h0);
    $display("clock failure done");
    complete_run();
  end
endmodule

/* cwd_config_word_one_decode_properties.sv */
`timescale 1ns/10ps
module cwd_cfg_props
  import cwd_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_arst_n,
  input wire logic [13:0] i_nv_word,
  input wire logic        i_low_voltage_prog_en,
  input wire logic        i_sleep_active,
  input wire logic        i_startup_timer_done,
  input wire logic        i_ext_clk_failed,
  input wire logic        o_fail_safe_monitor_en,
  input wire logic        o_two_speed_switchover_en,
  input wire logic        o_clock_out_drive,
  input wire logic        o_brownout_active,
  input wire logic        o_program_protect,
  input wire logic        o_reset_pin_is_master_reset,
  input wire logic        o_reset_pin_pullup_en,
  input wire logic        o_powerup_timer_en,
  input wire logic        o_watchdog_active,
  input wire logic        o_use_internal_clk,
  input wire logic        o_osc_fail_flag,
  input wire logic        o_config_loaded
);
  logic [13:0] w;
  logic        c;
  // Shadow copy of the word taken at the same edge as the design's capture.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      w <= CWD_WORD_ERASED;
      c <= 1'b0;
    end else if (!c) begin
      w <= i_nv_word;
      c <= 1'b1;
    end
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);
  sequence s_steady;
    o_config_loaded && $past(o_config_loaded);
  endsequence
  sequence s_fail;
    c && w[13] && i_startup_timer_done && i_ext_clk_failed;
  endsequence
  property p_erased;
    !o_config_loaded |-> o_fail_safe_monitor_en && !o_program_protect && !o_powerup_timer_en;
  endproperty
  property p_monitor;
    o_config_loaded |-> o_fail_safe_monitor_en == w[13];
  endproperty
  property p_switch;
    o_config_loaded |-> o_two_speed_switchover_en == (w[12] | w[13]);
  endproperty
  property p_clkout;
    o_config_loaded |-> o_clock_out_drive == (w[2:0] > 3'h2 && !w[11]);
  endproperty
  property p_bor;
    s_steady ##0 (w[10:9] != 2'h1)
      |-> o_brownout_active == (w[10] && (w[9] || !$past(i_sleep_active)));
  endproperty
  property p_protect;
    o_config_loaded |-> o_program_protect == !w[7];
  endproperty
  property p_pin;
    s_steady |-> o_reset_pin_is_master_reset == ($past(i_low_voltage_prog_en) | w[6])
      && (!o_reset_pin_is_master_reset || o_reset_pin_pullup_en);
  endproperty
  property p_pwrt;
    o_config_loaded |-> o_powerup_timer_en == !w[5];
  endproperty
  property p_wdt;
    s_steady ##0 (w[4:3] != 2'h1)
      |-> o_watchdog_active == (w[4] && (w[3] || !$past(i_sleep_active)));
  endproperty
  property p_fail;
    s_fail |=> o_osc_fail_flag && o_use_internal_clk;
  endproperty
  property p_hold;
    o_config_loaded |=> o_config_loaded && $stable(o_program_protect);
  endproperty
  a_erased: assert property (p_erased) else $error("erased defaults wrong");
  a_monitor: assert property (p_monitor) else $error("monitor enable wrong");
  a_switch: assert property (p_switch) else $error("switchover wrong");
  a_clkout: assert property (p_clkout) else $error("clock out wrong");
  a_bor: assert property (p_bor) else $error("brownout policy wrong");
  a_protect: assert property (p_protect) else $error("protection wrong");
  a_pin: assert property (p_pin) else $error("reset pin wrong");
  a_pwrt: assert property (p_pwrt) else $error("power-up timer wrong");
  a_wdt: assert property (p_wdt) else $error("watchdog policy wrong");
  a_fail: assert property (p_fail) else $error("clock failure missed");
  a_hold: assert property (p_hold) else $error("settings moved");
endmodule
bind cwd_config_word_one_decode cwd_cfg_props cwd_cfg_props_inst (.*);

/* cwd_pkg.sv */
// Summary of operation
// (R1) An erased word reads all ones, so every setting defaults to the field value of all ones.
// (R2) Bit 13 high enables the fail-safe clock monitor and the two-speed switchover, low disables the monitor.
// (R3) Bit 12 high enables the two-speed internal/external switchover mode, low disables it unless bit 13 is high.
// (R4) Bit 11 is ignored in crystal modes; otherwise one keeps the pin as I/O and zero drives clock out.
// (R5) The brown-out field gives 11 always on, 10 on except in sleep, 01 software bit, 00 off.
// (R6) Bit 7 high leaves program memory open, low turns code protection on.
// (R7) Bit 6 is ignored under low-voltage programming; else one is master reset with pull-up, zero is input.
// (R8) Bit 5 is an active-low power-up timer enable.
// (R9) The watchdog field gives 11 always on, 10 on except in sleep, 01 software bit, 00 off.
// (R10) Bit 8 is unimplemented and always reads back as one.
// (R11) With the monitor on, a failed external clock after start-up moves to the internal clock and flags it.
// (R12) Settings are captured from the word at reset and then held still until the next reset.
package cwd_pkg;

  localparam int unsigned CWD_WORD_W = 14;

  localparam logic [13:0] CWD_WORD_ERASED = 14'h3fff;

  localparam int unsigned CWD_BIT_MONITOR   = 13;
  localparam int unsigned CWD_BIT_SWITCH    = 12;
  localparam int unsigned CWD_BIT_CLKOUT_N  = 11;
  localparam int unsigned CWD_BIT_BOR_HI    = 10;
  localparam int unsigned CWD_BIT_BOR_LO    = 9;
  localparam int unsigned CWD_BIT_UNIMPL    = 8;
  localparam int unsigned CWD_BIT_PROTECT_N = 7;
  localparam int unsigned CWD_BIT_RESET_PIN = 6;
  localparam int unsigned CWD_BIT_PWRT_N    = 5;
  localparam int unsigned CWD_BIT_WDT_HI    = 4;
  localparam int unsigned CWD_BIT_WDT_LO    = 3;
  localparam int unsigned CWD_BIT_OSC_HI    = 2;
  localparam int unsigned CWD_BIT_OSC_LO    = 0;

  localparam logic [1:0] CWD_POL_ALWAYS = 2'h3;
  localparam logic [1:0] CWD_POL_AWAKE  = 2'h2;
  localparam logic [1:0] CWD_POL_SOFT   = 2'h1;
  localparam logic [1:0] CWD_POL_OFF    = 2'h0;

  localparam logic [2:0] CWD_OSC_LP = 3'h0;
  localparam logic [2:0] CWD_OSC_XT = 3'h1;
  localparam logic [2:0] CWD_OSC_HS = 3'h2;

  localparam logic [31:0] CWD_ADDR_WORD   = 32'h0000_0000;
  localparam logic [31:0] CWD_ADDR_CTRL   = 32'h0000_0004;
  localparam logic [31:0] CWD_ADDR_STATUS = 32'h0000_0008;

  localparam int unsigned CWD_CTRL_SW_BOR  = 0;
  localparam int unsigned CWD_CTRL_SW_WDT  = 1;
  localparam int unsigned CWD_CTRL_WPU     = 2;
  localparam int unsigned CWD_CTRL_RESTART = 3;

  localparam int unsigned CWD_STAT_FAIL     = 0;
  localparam int unsigned CWD_STAT_INTERNAL = 1;
  localparam int unsigned CWD_STAT_LOADED   = 2;

  localparam logic [2:0] CWD_CTRL_RESET = 3'h0;

  typedef enum logic {
    CWD_CAPTURE,
    CWD_HOLD
  } cwd_load_state_t;

  typedef struct packed {
    logic       fail_safe_monitor_en;
    logic       two_speed_switchover_en;
    logic       clock_out_pin_en_n;
    logic [1:0] brownout_policy_sel;
    logic       program_protect_n;
    logic       reset_pin_func_sel;
    logic       powerup_timer_en_n;
    logic [1:0] watchdog_policy_sel;
    logic [2:0] oscillator_source_sel;
  } cwd_cfg_t;

  localparam cwd_cfg_t CWD_CFG_ERASED = '{
    fail_safe_monitor_en:    1'b1,
    two_speed_switchover_en: 1'b1,
    clock_out_pin_en_n:      1'b1,
    brownout_policy_sel:     2'h3,
    program_protect_n:       1'b1,
    reset_pin_func_sel:      1'b1,
    powerup_timer_en_n:      1'b1,
    watchdog_policy_sel:     2'h3,
    oscillator_source_sel:   3'h7
  };

endpackage
